// ### rpps_host.sv
// Purpose: Host end: drives reset and power-down pulses, paces commands.
// Assumes: Same clock as the device end; long waits are parameters.
// Notes:   Calibration thresholds steer gain-up and gain-down request outputs.
`timescale 1ns/1ps
module rpps_host
#(
  parameter int unsigned SUPPLY_WAIT = rpps_pkg::SUPPLY_WAIT_CYC,
  parameter int unsigned CMD_WAIT    = rpps_pkg::CMD_WAIT_CYC,
  parameter int unsigned WAKE_WAIT   = rpps_pkg::WAKE_WAIT_CYC,
  parameter int unsigned SETTLE_CYC  = rpps_pkg::SETTLE_CYC_DEF
)
(
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  // Link
  rpps_if.host                               lnk,
  // User requests (reset, power-down and command are one-cycle pulses)
  input  wire logic                          reset_req_i,
  input  wire logic                          pdn_req_i,
  input  wire logic                          cmd_req_i,
  input  wire logic                          cmd_isolate_i,
  input  wire logic                          calibrating_i,
  // User status
  output logic                               busy_o,
  output logic                               cmd_ok_o,
  output logic                               result_ok_o,
  output logic [rpps_pkg::DATA_W-1:0]        result_o,
  output logic                               gain_up_o,
  output logic                               gain_down_o
);

  localparam int unsigned W = rpps_pkg::CNT_W + 4;
  localparam logic [rpps_pkg::DATA_W-1:0] FS   = {1'b0, {(rpps_pkg::DATA_W-1){1'b1}}};
  localparam logic [rpps_pkg::DATA_W-1:0] HI_T = rpps_pkg::DATA_W'(
    (longint'(FS) * rpps_pkg::CAL_HI_PCT) / 100);
  localparam logic [rpps_pkg::DATA_W-1:0] LO_T = rpps_pkg::DATA_W'(
    (longint'(FS) * rpps_pkg::CAL_LO_PCT) / 100);

  if (SUPPLY_WAIT < 1 || CMD_WAIT < 1 || WAKE_WAIT < 1 || SETTLE_CYC < rpps_pkg::FAST_DIV)
  begin : g_bad_par
    $error("Wait counts out of range.");
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {S_POWERUP, S_IDLE, S_RST_LOW, S_CMD_WAIT, S_PDN_LOW, S_WAKE} rpps_state_e;
  rpps_state_e          st;     // Sequencer state.
  logic [W-1:0]         cnt;    // Wait / pulse counter.

  // Pulse widths sit inside the legal windows, never in the undefined gap.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st  <= S_POWERUP;
      cnt <= '0;
      lnk.active_low_reset_pin <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 1'b1;
      unique case (st)
        S_POWERUP:
          if (cnt >= W'(SUPPLY_WAIT))
          begin
            st <= S_IDLE;
          end
        S_IDLE:
        begin
          cnt <= '0;
          if (reset_req_i)
          begin
            st <= S_RST_LOW;
            lnk.active_low_reset_pin <= 1'b0;
          end
          else if (pdn_req_i)
          begin
            st <= S_PDN_LOW;
            lnk.active_low_reset_pin <= 1'b0;
          end
        end
        S_RST_LOW:
          if (cnt >= W'(rpps_pkg::RST_DRIVE_CYC - 1))
          begin
            st  <= S_CMD_WAIT;
            cnt <= '0;
            lnk.active_low_reset_pin <= 1'b1;
          end
        S_CMD_WAIT:
          if (cnt >= W'(CMD_WAIT))
          begin
            st <= S_IDLE;
          end
        S_PDN_LOW:
          // Held low for at least PDN_DRIVE_CYC cycles, then until the user asks to wake.
          if (cnt >= W'(rpps_pkg::PDN_DRIVE_CYC) && reset_req_i)
          begin
            st  <= S_WAKE;
            cnt <= '0;
            lnk.active_low_reset_pin <= 1'b1;
          end
        S_WAKE:
          if (cnt >= W'(WAKE_WAIT))
          begin
            st <= S_IDLE;
          end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Commands and result pacing
  // ------------------------------------------------------------------
  logic [W-1:0] wait_cnt;   // Cycles since last command.

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lnk.cmd_valid   <= 1'b0;
      lnk.cmd_isolate <= 1'b0;
      wait_cnt        <= '0;
    end
    else
    begin
      lnk.cmd_valid <= cmd_req_i && st == S_IDLE;
      if (cmd_req_i && st == S_IDLE)
      begin
        lnk.cmd_isolate <= cmd_isolate_i;
        wait_cnt        <= '0;
      end
      else if (wait_cnt != {W{1'b1}})
      begin
        wait_cnt <= wait_cnt + 1'b1;
      end
    end
  end

  // Calibration may accept results after a tenth of settling; final reads
  // need the whole time and the device's own valid flag.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_o      <= 1'b1;
      cmd_ok_o    <= 1'b0;
      result_ok_o <= 1'b0;
      result_o    <= '0;
      gain_up_o   <= 1'b0;
      gain_down_o <= 1'b0;
    end
    else
    begin
      busy_o   <= st != S_IDLE;
      cmd_ok_o <= st == S_IDLE;
      if (calibrating_i)
      begin
        result_ok_o <= lnk.conv_ready
          && wait_cnt >= W'(SETTLE_CYC / rpps_pkg::FAST_DIV);
      end
      else
      begin
        result_ok_o <= lnk.conv_ready && lnk.conv_valid
          && wait_cnt >= W'(SETTLE_CYC);
      end
      if (lnk.conv_ready)
      begin
        result_o    <= lnk.conv_data;
        gain_down_o <= lnk.conv_data > HI_T;
        gain_up_o   <= lnk.conv_data < LO_T;
      end
    end
  end

endmodule

// ### rpps_pkg.sv
// Purpose: Shared constants for the reset / power-down pulse sequencer ends.
// Assumes: 40 MHz clock on both ends (25 ns period).
// Notes:   Times are kept in their printed unit; cycle counts derive from them.
package rpps_pkg;

  // ------------------------------------------------------------------
  // Clock rate
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1000000;

  // ------------------------------------------------------------------
  // Printed times
  // ------------------------------------------------------------------
  localparam int unsigned SUPPLY_WAIT_MS = 10;  // Supplies stable to first reset pulse.
  localparam int unsigned RST_MIN_US     = 25;  // Shortest reset pulse.
  localparam int unsigned RST_MAX_US     = 50;  // Longest reset pulse.
  localparam int unsigned CMD_WAIT_MS    = 1;   // Reset end to first serial command.
  localparam int unsigned PDN_MIN_US     = 200; // Pulse width that means power-down.
  localparam int unsigned WAKE_WAIT_MS   = 10;  // Power-down exit to next reset.
  localparam int unsigned FAST_DIV       = 10;  // Settling divisor while calibrating.

  // ------------------------------------------------------------------
  // Cycle counts (least times round up; at 40 MHz all are exact)
  // ------------------------------------------------------------------
  localparam int unsigned RST_MIN_CYC    = RST_MIN_US * CYC_PER_US;
  localparam int unsigned RST_MAX_CYC    = RST_MAX_US * CYC_PER_US;
  localparam int unsigned PDN_MIN_CYC    = PDN_MIN_US * CYC_PER_US;
  localparam int unsigned SUPPLY_WAIT_CYC = SUPPLY_WAIT_MS * 1000 * CYC_PER_US + 1;
  localparam int unsigned CMD_WAIT_CYC   = CMD_WAIT_MS * 1000 * CYC_PER_US + 1;
  localparam int unsigned WAKE_WAIT_CYC  = WAKE_WAIT_MS * 1000 * CYC_PER_US + 1;
  localparam int unsigned SETTLE_CYC_DEF = 1000;  // Channel settling time, plain default.
  // Host drives the middle of the reset window.
  localparam int unsigned RST_DRIVE_CYC  = (RST_MIN_CYC + RST_MAX_CYC) / 2;
  // Host drives a power-down pulse comfortably above the minimum.
  localparam int unsigned PDN_DRIVE_CYC  = PDN_MIN_CYC + CYC_PER_US * 10;

  // ------------------------------------------------------------------
  // Calibration thresholds (percent of full scale) and data width
  // ------------------------------------------------------------------
  localparam int unsigned CAL_HI_PCT     = 80;
  localparam int unsigned CAL_LO_PCT     = 20;
  localparam int unsigned DATA_W         = 24;
  localparam int unsigned CNT_W          = 24;

endpackage

// ### rpps_if.sv
// Purpose: Link between the sensing front end and its host controller.
// Assumes: Single clock; the reset pin is a plain push-pull line from host.
// Notes:   Carries the reset pin, command strobe and conversion-ready pulse.
`timescale 1ns/1ps
interface rpps_if;
  logic                                active_low_reset_pin; // Host-driven reset pin.
  logic                                cmd_valid;            // One-cycle serial command strobe.
  logic                                cmd_isolate;          // Command payload: isolate mode bit.
  logic                                conv_ready;           // One-cycle conversion-ready pulse.
  logic                                conv_valid;           // Result settled flag with the pulse.
  logic [rpps_pkg::DATA_W-1:0]         conv_data;            // Converted result.

  modport dev
  (
    input  active_low_reset_pin,
    input  cmd_valid,
    input  cmd_isolate,
    output conv_ready,
    output conv_valid,
    output conv_data
  );

  modport host
  (
    output active_low_reset_pin,
    output cmd_valid,
    output cmd_isolate,
    input  conv_ready,
    input  conv_valid,
    input  conv_data
  );
endinterface

// ### rpps_dev.sv
// Purpose: Front-end end: measures reset pulses, tracks power-down, settling.
// Assumes: Reset pin is asynchronous to mclk_i and is synchronised here.
// Notes:   Analog path is modelled by two user-side current inputs.
`timescale 1ns/1ps

// Functional notes
// - Host waits over 10 ms before first reset.
// - Pulse 25-50 us causes full reset.
// - Host waits over 1 ms before commands.
// - Valid result only after one settling time.
// - Low over 200 us enters power-down.
// - Host waits 10 ms after power-down exit.
// - Isolate mode converts offset current only.
// - Calibrating host may wait tenth settling.
// - Settled host waits full settling time.
// - Host thresholds 80% and 20% trigger changes.
module rpps_dev
#(
  parameter int unsigned SETTLE_CYC = rpps_pkg::SETTLE_CYC_DEF
)
(
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  // Link
  rpps_if.dev                                lnk,
  // Analog stand-ins
  input  wire logic [rpps_pkg::DATA_W-1:0]   photo_current_i,
  input  wire logic [rpps_pkg::DATA_W-1:0]   offset_cancel_current_i,
  input  wire logic                          sample_tick_i,
  // Status
  output logic                               power_down_state_o,
  output logic                               device_reset_o,
  output logic                               photodiode_isolate_mode_o
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << rpps_pkg::CNT_W))
  begin : g_bad_settle
    $error("Settling count out of range.");
  end

  // ------------------------------------------------------------------
  // Reset pin synchroniser
  // ------------------------------------------------------------------
  logic                        pin_meta;   // First stage; read by pin_sync only.
  logic                        pin_sync;   // Second stage, safe to use.
  logic                        pin_prev;   // Previous synchronised level.

  // Two flops keep metastability off the pulse-width counter.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end
    else
    begin
      pin_meta <= lnk.active_low_reset_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // ------------------------------------------------------------------
  // Low pulse width measurement
  // ------------------------------------------------------------------
  logic [rpps_pkg::CNT_W-1:0]  low_cnt;    // Cycles the pin has been low, saturating.
  logic                        rise;       // Pin released this cycle.

  // The edge is taken from synchronised copies only, so a glitch on the
  // pin can never be seen by one consumer and missed by another.
  assign rise = pin_sync & ~pin_prev;

  // The counter saturates so a very long hold cannot wrap into the reset window.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      low_cnt <= '0;
    end
    else if (pin_sync)
    begin
      low_cnt <= '0;
    end
    else if (low_cnt != {rpps_pkg::CNT_W{1'b1}})
    begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Reset and power-down decisions
  // ------------------------------------------------------------------
  // Power-down is entered while the pin is still held, once the width passes
  // the threshold; release of the pin leaves it. A pulse in the undefined gap
  // between the two windows is ignored here.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      power_down_state_o <= 1'b0;
    end
    else if (!pin_sync && low_cnt >= rpps_pkg::CNT_W'(rpps_pkg::PDN_MIN_CYC))
    begin
      power_down_state_o <= 1'b1;
    end
    else if (pin_sync)
    begin
      power_down_state_o <= 1'b0;
    end
  end

  // Full reset is a one-cycle pulse at the end of a pulse inside the window.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      device_reset_o <= 1'b0;
    end
    else
    begin
      device_reset_o <= rise && low_cnt >= rpps_pkg::CNT_W'(rpps_pkg::RST_MIN_CYC)
                        && low_cnt <= rpps_pkg::CNT_W'(rpps_pkg::RST_MAX_CYC);
    end
  end

  // ------------------------------------------------------------------
  // Configuration: isolate mode
  // ------------------------------------------------------------------
  // Commands are ignored during power-down and while the pin is low.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      photodiode_isolate_mode_o <= 1'b0;
    end
    else if (device_reset_o)
    begin
      photodiode_isolate_mode_o <= 1'b0;
    end
    else if (lnk.cmd_valid && pin_sync && !power_down_state_o)
    begin
      photodiode_isolate_mode_o <= lnk.cmd_isolate;
    end
  end

  // ------------------------------------------------------------------
  // Settling timer
  // ------------------------------------------------------------------
  logic [rpps_pkg::CNT_W-1:0]  settle_cnt; // Cycles left before results are valid.

  // Any accepted command or reset restarts settling, since the signal
  // chain needs a full channel time after each change.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      settle_cnt <= rpps_pkg::CNT_W'(SETTLE_CYC);
    end
    else if (device_reset_o || power_down_state_o
             || (lnk.cmd_valid && pin_sync))
    begin
      settle_cnt <= rpps_pkg::CNT_W'(SETTLE_CYC);
    end
    else if (settle_cnt != '0)
    begin
      settle_cnt <= settle_cnt - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Conversion output
  // ------------------------------------------------------------------
  // The result is the offset current alone when isolated, else the sum.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lnk.conv_ready <= 1'b0;
      lnk.conv_valid <= 1'b0;
      lnk.conv_data  <= '0;
    end
    else
    begin
      lnk.conv_ready <= sample_tick_i && !power_down_state_o;
      lnk.conv_valid <= sample_tick_i && !power_down_state_o && settle_cnt == '0;
      if (sample_tick_i && !power_down_state_o)
      begin
        if (photodiode_isolate_mode_o)
        begin
          lnk.conv_data <= offset_cancel_current_i;
        end
        else
        begin
          lnk.conv_data <= photo_current_i + offset_cancel_current_i;
        end
      end
    end
  end

endmodule

// ### rpps_monitor.sv
// Purpose: Watches the link between host end and front-end end for timing faults.
// Assumes: One clock; helper counters saturate so long holds never wrap.
// Notes:   Long waits arrive as parameters matching those given to the host end.
`timescale 1ns/1ps
module rpps_monitor
#(
  parameter int unsigned SUPPLY_WAIT = rpps_pkg::SUPPLY_WAIT_CYC,
  parameter int unsigned CMD_WAIT    = rpps_pkg::CMD_WAIT_CYC,
  parameter int unsigned WAKE_WAIT   = rpps_pkg::WAKE_WAIT_CYC,
  parameter int unsigned SETTLE_CYC  = rpps_pkg::SETTLE_CYC_DEF
)
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  // Link signals
  input  wire logic                        active_low_reset_pin,
  input  wire logic                        cmd_valid,
  input  wire logic                        cmd_isolate,
  input  wire logic                        conv_ready,
  input  wire logic                        conv_valid,
  input  wire logic [rpps_pkg::DATA_W-1:0] conv_data
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [23:0] low_cnt;  // Cycles the pin has been low.
  logic [23:0] high_cnt; // Cycles the pin has been high.
  logic [23:0] up_cnt;   // Cycles since reset release.
  logic [23:0] cmd_cnt;  // Cycles since the last command.
  logic        was_pdn;  // The last finished pulse was a power-down.

  // Run lengths of the pin; saturation keeps a long power-down from wrapping.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      low_cnt  <= 24'h000000;
      high_cnt <= 24'h000000;
      up_cnt   <= 24'h000000;
    end
    else
    begin
      low_cnt  <= active_low_reset_pin ? 24'h000000 : low_cnt + {23'h000000, ~&low_cnt};
      high_cnt <= !active_low_reset_pin ? 24'h000000 : high_cnt + {23'h000000, ~&high_cnt};
      up_cnt   <= up_cnt + {23'h000000, ~&up_cnt};
    end
  end

  // Settling age starts as long ago, so results before any command are not judged.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cmd_cnt <= 24'hFFFFFF;
    else if (cmd_valid)
      cmd_cnt <= 24'h000000;
    else
      cmd_cnt <= cmd_cnt + {23'h000000, ~&cmd_cnt};
  end

  // Remember at each release whether the pulse meant power-down.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      was_pdn <= 1'b0;
    else if (active_low_reset_pin && (low_cnt != 24'h000000))
      was_pdn <= (low_cnt >= rpps_pkg::PDN_MIN_CYC);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_release;
    $rose(active_low_reset_pin);
  endsequence

  sequence s_pulse_start;
    $fell(active_low_reset_pin);
  endsequence

  AST_PULSE_WIDTH: assert property (s_release |->
    ((low_cnt >= rpps_pkg::RST_MIN_CYC) && (low_cnt <= rpps_pkg::RST_MAX_CYC)) || (low_cnt >= rpps_pkg::PDN_MIN_CYC))
    else $error("Reset pin pulse width outside both windows.");
  AST_SUPPLY_WAIT: assert property (s_pulse_start |-> up_cnt >= SUPPLY_WAIT - 1)
    else $error("Reset pulse started before the supply wait.");
  AST_CMD_WAIT: assert property (cmd_valid |-> high_cnt >= CMD_WAIT - 1)
    else $error("Command issued too soon after a reset pulse.");
  AST_CMD_PIN_HIGH: assert property (cmd_valid |-> active_low_reset_pin && $past(active_low_reset_pin))
    else $error("Command issued while the reset pin was low.");
  AST_WAKE_WAIT: assert property (s_pulse_start and was_pdn |-> high_cnt >= WAKE_WAIT - 1)
    else $error("Reset pulse too soon after power-down exit.");
  AST_VALID_SETTLE: assert property (conv_ready && conv_valid |-> cmd_cnt >= SETTLE_CYC)
    else $error("Valid result before one settling time.");
  // A device reset also restarts settling, so the pin must have been high a full settling time too.
  AST_VALID_AFTER: assert property (conv_ready && (cmd_cnt >= SETTLE_CYC + 4) && (cmd_cnt != 24'hFFFFFF)
    && (high_cnt >= SETTLE_CYC + 8) |-> conv_valid)
    else $error("Settled result not marked valid.");
  AST_NO_CONV_PDN: assert property (!active_low_reset_pin && (low_cnt > rpps_pkg::PDN_MIN_CYC + 6) |-> !conv_ready)
    else $error("Conversion reported during power-down.");
  AST_DATA_HELD: assert property ($changed(conv_data) |-> conv_ready)
    else $error("Result changed without a conversion pulse.");
endmodule

// ### reset_powerdown_pulse_sequencer_tb.sv
// Purpose: Drives host and front-end ends back to back and judges the link.
// Assumes: 40 MHz clock; host waits shortened by parameters.
// Notes:   Inputs change at the falling edge only.
`timescale 1ns/1ps
module reset_powerdown_pulse_sequencer_tb;
  // ----------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------
  localparam int unsigned SUP_W = 100; // Shortened supply wait.
  localparam int unsigned CMD_W = 50;  // Shortened command wait.
  localparam int unsigned WAK_W = 120; // Shortened wake wait.
  localparam int unsigned SETL  = 40;  // Shortened settling time.
  localparam logic [23:0] PHO   = 24'h001200; // Photodiode stand-in.
  localparam logic [23:0] OFS   = 24'h000340; // Offset stand-in.
  logic        mclk_i, rstn_i, tick, rst_req, pdn_req, cmd_req, iso, cal;
  logic        busy, cmd_ok, res_ok, gup, gdn, pdn, dres, isom;
  logic [23:0] res;
  int          n_errors, samples_checked;
  rpps_if lnk();

  rpps_dev #(.SETTLE_CYC(SETL)) u_rpps_dev (.mclk_i(mclk_i), .rstn_i(rstn_i), .lnk(lnk),
    .photo_current_i(PHO), .offset_cancel_current_i(OFS), .sample_tick_i(tick),
    .power_down_state_o(pdn), .device_reset_o(dres), .photodiode_isolate_mode_o(isom));
  rpps_host #(.SUPPLY_WAIT(SUP_W), .CMD_WAIT(CMD_W), .WAKE_WAIT(WAK_W), .SETTLE_CYC(SETL)) u_rpps_host (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .lnk(lnk), .reset_req_i(rst_req), .pdn_req_i(pdn_req),
    .cmd_req_i(cmd_req), .cmd_isolate_i(iso), .calibrating_i(cal), .busy_o(busy), .cmd_ok_o(cmd_ok),
    .result_ok_o(res_ok), .result_o(res), .gain_up_o(gup), .gain_down_o(gdn));
  rpps_monitor #(.SUPPLY_WAIT(SUP_W), .CMD_WAIT(CMD_W), .WAKE_WAIT(WAK_W), .SETTLE_CYC(SETL)) u_mon (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .active_low_reset_pin(lnk.active_low_reset_pin),
    .cmd_valid(lnk.cmd_valid), .cmd_isolate(lnk.cmd_isolate), .conv_ready(lnk.conv_ready),
    .conv_valid(lnk.conv_valid), .conv_data(lnk.conv_data));

  // Free-running 40 MHz clock.
  always #12.5 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares with case equality so an unknown never passes.
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counts falling edges until a condition holds, with a bound against hangs.
  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    while (lnk.active_low_reset_pin !== lvl && n < 20000)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 20000) n_errors++; // A stuck pin counts as a mismatch.
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 20000) n_errors++; // A host that never idles counts as a mismatch.
  endtask

  // Requests one conversion; ready is looked at in the one cycle it stands.
  task automatic sample(output logic r, output logic v, output logic [23:0] d, output logic k);
    tick = 1'b1;
    @(negedge mclk_i);
    tick = 1'b0;
    r = lnk.conv_ready;
    v = lnk.conv_valid;
    d = lnk.conv_data;
    @(negedge mclk_i);
    k = res_ok;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // The pin must stay high through the supply wait.
  task automatic t_powerup();
    int n;
    wait_idle(n);
    chk("supply wait", 24'h1, 24'(n + 2 >= SUP_W));
    chk("pin idle", 24'h1, 24'(lnk.active_low_reset_pin));
    chk("no power-down", 24'h0, 24'(pdn));
    chk("cmd ok", 24'h1, 24'(cmd_ok));
  endtask

  // A reset pulse lands in its window, resets once, then commands wait.
  task automatic t_reset();
    int n, w, seen;
    rst_req = 1'b1;
    @(negedge mclk_i);
    rst_req = 1'b0;
    wait_pin(1'b0, n);
    wait_pin(1'b1, w);
    chk("reset width", 24'h1, 24'(w >= rpps_pkg::RST_MIN_CYC && w <= rpps_pkg::RST_MAX_CYC));
    seen = 0;
    repeat (8)
    begin
      @(negedge mclk_i);
      seen += int'(dres === 1'b1);
    end
    chk("device reset pulses", 24'h1, 24'(seen));
    chk("isolate cleared", 24'h0, 24'(isom));
    wait_idle(n);
    chk("command wait", 24'h1, 24'(n + 9 >= CMD_W));
  endtask

  // A command sets the mode; results count as valid only after settling.
  task automatic t_cmd(input logic mode, input logic c);
    logic r, v, k;
    logic [23:0] d, e;
    e = mode ? OFS : PHO + OFS;
    cal = c;
    iso = mode;
    cmd_req = 1'b1;
    @(negedge mclk_i);
    cmd_req = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("isolate mode", 24'(mode), 24'(isom));
    sample(r, v, d, k);
    chk("early ready", 24'h1, 24'(r));
    chk("early valid", 24'h0, 24'(v));
    chk("early result ok", 24'(c), 24'(k));
    chk("early data", e, d);
    repeat (SETL + 4) @(negedge mclk_i);
    sample(r, v, d, k);
    chk("settled valid", 24'h1, 24'(v));
    chk("settled result ok", 24'h1, 24'(k));
    chk("settled data", e, d);
    chk("host result", e, res);
    // Both stand-in results sit far below the low threshold of full scale.
    chk("gain up", 24'h1, 24'(gup));
    chk("gain down", 24'h0, 24'(gdn));
  endtask

  // A long hold enters power-down, refuses conversions, and paces the next reset.
  task automatic t_pdn();
    int n;
    logic r, v, k;
    logic [23:0] d;
    pdn_req = 1'b1;
    @(negedge mclk_i);
    pdn_req = 1'b0;
    wait_pin(1'b0, n);
    n = 0;
    while (pdn !== 1'b1 && n < 20000)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk("power-down entry", 24'h1, 24'(n + 2 >= rpps_pkg::PDN_MIN_CYC && n <= rpps_pkg::PDN_MIN_CYC + 6));
    sample(r, v, d, k);
    chk("ready in power-down", 24'h0, 24'(r));
    repeat (600) @(negedge mclk_i);
    rst_req = 1'b1;
    @(negedge mclk_i);
    rst_req = 1'b0;
    wait_pin(1'b1, n);
    repeat (6) @(negedge mclk_i);
    chk("power-down exit", 24'h0, 24'(pdn));
    wait_idle(n);
    chk("wake wait", 24'h1, 24'(n + 8 >= WAK_W));
  endtask

  // ----------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {mclk_i, rstn_i, tick, rst_req, pdn_req, cmd_req, iso, cal} = 8'h00;
    n_errors = 0;
    samples_checked = 0;
    repeat (6) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_powerup();
    t_reset();
    // Isolate mode is left set here so that the last reset has something to clear.
    t_cmd(1'b0, 1'b1);
    t_cmd(1'b1, 1'b0);
    t_pdn();
    t_reset();
    final_report();
  end

  // Whole run needs about 12000 cycles; this cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    n_errors++;
    final_report();
  end
endmodule
